// *** src/cog_map.vh ***
// Register offsets, field positions and reset values for output gating.
`ifndef COG_MAP_VH
`define COG_MAP_VH

`define COG_ADDR_OUTPUT 12'h000
`define COG_ADDR_CTRL 12'h004
`define COG_ADDR_STATUS 12'h008

`define COG_OUT_HF_EN 0
`define COG_OUT_LF_EN 1
`define COG_OUT_FB_EN 2
`define COG_OUT_FB_SQ 3
`define COG_OUT_DRIVE 4
`define COG_OUT_MAIN_SQ 5
`define COG_OUT_SLEW 6
`define COG_OUT_W 7
`define COG_OUT_RST 7'h6b

`define COG_CTL_HF_DIS 0
`define COG_CTL_LF_DIS 1
`define COG_CTL_FB_DIS 2
`define COG_CTL_RECAL 3
`define COG_CTL_W 4
`define COG_CTL_RST 4'h0

`define COG_ST_LOCKED 0
`define COG_ST_HF_STATE 1
`define COG_ST_LF_STATE 3
`define COG_ST_FB_TOG 5
`define COG_ST_POR 6
`define COG_ST_W 7

`define COG_POR_CYCLES 4'hf

`endif

// *** src/cog_out_sel.v ***
// Output state decoder for one tri-statable main clock output.
`timescale 1ns/1ps
`default_nettype none

module cog_out_sel (
  // Conditions.
  input wire por_act,
  input wire reset_act,
  input wire oe_pin_n,
  input wire locked,
  input wire squelch_en,
  input wire out_en,
  input wire div_dis,
  // Result: toggle or drive low or high impedance.
  output reg tog,
  output reg drv_low,
  output reg hiz
);

  always @* begin
    tog = 1'b0;
    drv_low = 1'b0;
    hiz = 1'b0;
    if (por_act) begin
      hiz = 1'b1;
    end else if (reset_act) begin
      if (oe_pin_n) begin
        hiz = 1'b1;
      end else begin
        drv_low = 1'b1;
      end
    end else if (oe_pin_n || !out_en) begin
      hiz = 1'b1;
    end else if (div_dis) begin
      drv_low = 1'b1;
    end else if (locked || !squelch_en) begin
      tog = 1'b1;
    end else begin
      drv_low = 1'b1;
    end
  end

endmodule // cog_out_sel

`default_nettype wire

// *** src/cog_gate.v ***
// Clock output gating control with APB register access.
// Summary of operation
// - Each main output toggles, drives low, or floats.
// - Power-on reset floats; reset pin follows enable pin.
// - Enable pin high or enable bit clear floats.
// - Disabled divider drives low, else toggles.
// - Unlocked with squelch set drives low.
// - One squelch bit serves both main outputs.
// - Feedback clock never floats, ignores enable pin.
// - Feedback toggles only when fully enabled.
// - Feedback squelch has its own bit.
// - Slow edges bit set limits edge rate.
// - Slow edges bit resets to set.
// - Recalibration start drops lock at once.
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "cog_map.vh"

module cog_gate (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // APB slave.
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Device pins and clock sources.
  input wire reset_pin_n,
  input wire output_enable_pin_n,
  input wire pll_locked,
  input wire hf_clk_src,
  input wire lf_clk_src,
  input wire fb_clk_src,
  // Clock outputs, the two main ones with enables; enable high means driven.
  output reg hf_diff_clock_out,
  output reg hf_diff_clock_oe,
  output reg lf_cmos_clock_out,
  output reg lf_cmos_clock_oe,
  output reg fb_clock_out,
  // Open-drain lock pin: low drives the pin low.
  output reg lock_detect_n,
  output reg lock_detect_oe,
  // Pad controls for the CMOS output.
  output reg cmos_drive_boost,
  output reg cmos_slow_edges
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  reg [4:0] sync1_ff;
  reg [4:0] sync2_ff;
  wire rstpin_s = sync2_ff[0];
  wire oepin_s = sync2_ff[1];
  wire lock_s = sync2_ff[2];

  always @(posedge clk) begin
    if (!rst_b) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
    end else begin
      sync1_ff <= {fb_clk_src, lf_clk_src, pll_locked,
                   output_enable_pin_n, reset_pin_n};
      sync2_ff <= sync1_ff;
    end
  end

  // ---------------------------------------------------------------
  // Power-on reset stretch
  // ---------------------------------------------------------------
  reg [3:0] por_cnt_ff;
  wire por_act = (por_cnt_ff != `COG_POR_CYCLES);

  always @(posedge clk) begin
    if (!rst_b) begin
      por_cnt_ff <= 4'h0;
    end else if (por_act) begin
      por_cnt_ff <= por_cnt_ff + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [`COG_OUT_W-1:0] out_ff;
  reg [`COG_CTL_W-1:0] ctl_ff;
  reg recal_ff;
  wire wr = psel && penable && pwrite;
  wire wr_out = wr && (paddr == `COG_ADDR_OUTPUT);
  wire wr_ctl = wr && (paddr == `COG_ADDR_CTRL);
  wire recal_start = wr_ctl && pwdata[`COG_CTL_RECAL];

  always @(posedge clk) begin
    if (!rst_b) begin
      out_ff <= `COG_OUT_RST;
      ctl_ff <= `COG_CTL_RST;
    end else begin
      if (wr_out) begin
        out_ff <= pwdata[`COG_OUT_W-1:0];
      end
      if (wr_ctl) begin
        ctl_ff <= pwdata[`COG_CTL_W-1:0];
      end
    end
  end

  // Recalibration holds lock low until the PLL reports lock again.
  always @(posedge clk) begin
    if (!rst_b) begin
      recal_ff <= 1'b0;
    end else if (recal_start) begin
      recal_ff <= 1'b1;
    end else if (lock_s) begin
      recal_ff <= 1'b0;
    end
  end

  wire locked = lock_s && !recal_ff && !recal_start;
  wire reset_act = !rstpin_s;
  wire main_sq = out_ff[`COG_OUT_MAIN_SQ];

  // ---------------------------------------------------------------
  // Output state decode
  // ---------------------------------------------------------------
  wire hf_tog;
  wire hf_low;
  wire hf_hiz;
  wire lf_tog;
  wire lf_low;
  wire lf_hiz;

  cog_out_sel u_hf (
    .por_act(por_act),
    .reset_act(reset_act),
    .oe_pin_n(oepin_s),
    .locked(locked),
    .squelch_en(main_sq),
    .out_en(out_ff[`COG_OUT_HF_EN]),
    .div_dis(ctl_ff[`COG_CTL_HF_DIS]),
    .tog(hf_tog),
    .drv_low(hf_low),
    .hiz(hf_hiz)
  );

  cog_out_sel u_lf (
    .por_act(por_act),
    .reset_act(reset_act),
    .oe_pin_n(oepin_s),
    .locked(locked),
    .squelch_en(main_sq),
    .out_en(out_ff[`COG_OUT_LF_EN]),
    .div_dis(ctl_ff[`COG_CTL_LF_DIS]),
    .tog(lf_tog),
    .drv_low(lf_low),
    .hiz(lf_hiz)
  );

  // Feedback clock is never floated and ignores the enable pin.
  wire fb_tog = !por_act && !reset_act && out_ff[`COG_OUT_FB_EN] &&
                !ctl_ff[`COG_CTL_FB_DIS] &&
                (locked || !out_ff[`COG_OUT_FB_SQ]);

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      hf_diff_clock_out <= 1'b0;
      hf_diff_clock_oe <= 1'b0;
      lf_cmos_clock_out <= 1'b0;
      lf_cmos_clock_oe <= 1'b0;
      fb_clock_out <= 1'b0;
      lock_detect_n <= 1'b0;
      lock_detect_oe <= 1'b1;
      cmos_drive_boost <= 1'b0;
      cmos_slow_edges <= 1'b1;
    end else begin
      hf_diff_clock_out <= hf_tog & hf_clk_src;
      hf_diff_clock_oe <= !hf_hiz;
      lf_cmos_clock_out <= lf_tog & sync2_ff[3];
      lf_cmos_clock_oe <= !lf_hiz;
      fb_clock_out <= fb_tog & sync2_ff[4];
      lock_detect_n <= locked;
      lock_detect_oe <= !locked;
      cmos_drive_boost <= out_ff[`COG_OUT_DRIVE];
      cmos_slow_edges <= out_ff[`COG_OUT_SLEW];
    end
  end

  // ---------------------------------------------------------------
  // APB read path
  // ---------------------------------------------------------------
  wire [`COG_ST_W-1:0] status = {por_act, fb_tog, lf_hiz, lf_tog,
                                 hf_hiz, hf_tog, locked};
  wire setup = psel && !penable;
  wire mapped = (paddr == `COG_ADDR_OUTPUT) || (paddr == `COG_ADDR_CTRL) ||
                (paddr == `COG_ADDR_STATUS);

  always @(posedge clk) begin
    if (!rst_b) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= 32'h0;
      if (setup && !pwrite) begin
        case (paddr)
          `COG_ADDR_OUTPUT: prdata <= {25'h0, out_ff};
          `COG_ADDR_CTRL: prdata <= {28'h0, recal_ff, ctl_ff[2:0]};
          `COG_ADDR_STATUS: prdata <= {25'h0, status};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

endmodule // cog_gate

`default_nettype wire

// *** verif/cog_src.sv ***
// Source clock model for the block's clock inputs.
`timescale 1ns/1ps
`default_nettype none
module cog_src (
  // Reference clock.
  input wire logic clk,
  // Divided source clocks.
  output logic hf,
  output logic lf,
  output logic fb
);
  logic [2:0] cnt_ff = 3'h0;
  always @(posedge clk) cnt_ff <= cnt_ff + 3'h1;
  assign hf = cnt_ff[0];
  assign lf = cnt_ff[1];
  assign fb = cnt_ff[2];
endmodule // cog_src
`default_nettype wire

// *** verif/cog_gate_asserts.sv ***
// Port assertions for the clock output gating block.
`timescale 1ns/1ps
`default_nettype none
module cog_gate_asserts (
  // Clock, reset and bus.
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and outputs.
  input wire logic reset_pin_n,
  input wire logic output_enable_pin_n,
  input wire logic pll_locked,
  input wire logic hf_diff_clock_oe,
  input wire logic lf_cmos_clock_oe,
  input wire logic fb_clock_out,
  input wire logic lock_detect_oe,
  input wire logic cmos_drive_boost,
  input wire logic cmos_slow_edges
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence setup_s; psel && !penable; endsequence
  sequence wr_out_s; psel && penable && pwrite && paddr == 12'h000; endsequence
  a_ready_pulse: assert property (setup_s |=> pready ##1 !pready)
    else $error("ready not a single pulse");
  a_idle_quiet: assert property (!psel |=> !pready)
    else $error("ready without a transfer");
  a_bad_addr: assert property ((setup_s and (paddr > 12'h008)) |=> pslverr)
    else $error("no error on unmapped address");
  a_pad_bits: assert property (wr_out_s |=> ##1
    cmos_slow_edges == $past(pwdata[6], 2) && cmos_drive_boost == $past(pwdata[4], 2))
    else $error("pad bits do not follow register");
  a_oe_pin_hiz: assert property (output_enable_pin_n [*4] |=>
    !hf_diff_clock_oe && !lf_cmos_clock_oe) else $error("main output driven");
  a_fb_reset_low: assert property (!reset_pin_n [*4] |=> !fb_clock_out)
    else $error("feedback clock high in reset");
  a_unlock_pin: assert property (!pll_locked [*4] |=> lock_detect_oe)
    else $error("lock pin released while unlocked");
  a_recal_drop: assert property (psel && penable && pwrite &&
    paddr == 12'h004 && pwdata[3] |=> lock_detect_oe) else $error("no drop");
endmodule // cog_gate_asserts
bind cog_gate cog_gate_asserts chk_u (.clk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .reset_pin_n, .output_enable_pin_n,
  .pll_locked, .hf_diff_clock_oe, .lf_cmos_clock_oe, .fb_clock_out,
  .lock_detect_oe, .cmos_drive_boost, .cmos_slow_edges);
`default_nettype wire

// *** verif/tb.sv ***
// Self-checking bench for the clock output gating block.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, hfs, lfs, fbs, hoe, boost, slow;
  logic rpin = 1, oen = 0, lk = 1;
  logic hout, fbo, ldo;
  int err_count = 0, n_checks = 0;
  always #4 clk = ~clk;
  cog_src src_u (.clk, .hf(hfs), .lf(lfs), .fb(fbs));
  cog_gate dut_u (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .reset_pin_n(rpin), .output_enable_pin_n(oen),
    .pll_locked(lk), .hf_clk_src(hfs), .lf_clk_src(lfs), .fb_clk_src(fbs),
    .hf_diff_clock_out(hout), .hf_diff_clock_oe(hoe), .lf_cmos_clock_out(),
    .lf_cmos_clock_oe(), .fb_clock_out(fbo), .lock_detect_n(),
    .lock_detect_oe(ldo), .cmos_drive_boost(boost), .cmos_slow_edges(slow));
  task stop_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1 && i < 20) begin
      i++;
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (i == 20) begin
      err_count++;
      stop_test;
    end
  endtask
  // Returns hi-Z and toggling flags of one main output.
  function automatic logic [1:0] st(input logic r, o, l, q, e, d);
    if (!r) return {o, 1'b0};
    if (o || !e) return 2'b10;
    return {1'b0, !d && (l || !q)};
  endfunction
  initial begin
    logic [1:0] m;
    logic [5:0] c;
    logic [1:0] sn;
    repeat (10) @(posedge clk);
    rst_b <= 1;
    apb(0, 12'h008, 32'h0);
    chk(rd & 32'h54, 32'h54);
    chk({31'h0, slow}, 32'h1);
    apb(0, 12'h000, 32'h0);
    chk(rd, 32'h6b);
    repeat (20) @(posedge clk);
    for (int i = 0; i < 64; i++) begin
      c = i[5:0];
      apb(1, 12'h000, {25'h0, 1'b1, c[2], 1'b0, !c[2], {3{c[1]}}});
      apb(1, 12'h004, {29'h0, {3{c[0]}}});
      rpin <= c[5];
      oen <= c[4];
      lk <= c[3];
      repeat (6) @(posedge clk);
      apb(0, 12'h008, 32'h0);
      m = st(c[5], c[4], c[3], c[2], c[1], c[0]);
      chk(rd & 32'h3e, {26'h0, c[5] & c[1] & !c[0] & (c[3] | c[2]), m, m,
        1'b0});
      chk({31'h0, hoe}, {31'h0, !m[1]});
    end
    rpin <= 1;
    oen <= 0;
    lk <= 1;
    apb(1, 12'h000, 32'h33);
    repeat (3) @(posedge clk);
    chk({30'h0, boost, slow}, 32'h2);
    apb(1, 12'h004, 32'h8);
    apb(0, 12'h00c, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    // Dividers are back on and lock is steady: the main output must toggle.
    repeat (6) @(posedge clk);
    sn = 2'b00;
    repeat (8) begin
      @(posedge clk);
      sn = sn | {hout, !hout};
    end
    chk({30'h0, sn}, 32'h3);
    chk({31'h0, fbo}, 32'h0);
    chk({31'h0, ldo}, 32'h0);
    stop_test;
  end
endmodule // tb
`default_nettype wire
